/* adc_seq_map.svh */
/*
 Register offsets, field positions, reset values and timing counts
 of the conversion sequencer. Assumes a 32-bit AHB-Lite register bus.
*/
`ifndef ADC_SEQ_MAP_SVH
`define ADC_SEQ_MAP_SVH

// ------------------------------------------------------------
// Offsets
// ------------------------------------------------------------
`define OFS_CONFIG     8'h00
`define OFS_TIMING     8'h04
`define OFS_STATUS     8'h08
`define OFS_RESULT     8'h0c

// ------------------------------------------------------------
// Fields
// ------------------------------------------------------------
`define CFG_ENABLE     0
`define CFG_POWER_OFF  1
`define CFG_TRIG_LO    2
`define CFG_RES_SEL    4
`define CFG_CLK_SRC    5
`define CFG_RPT_LO     8
`define TIM_TRACK_LO   0
`define TIM_PWR_LO     8
`define TIM_DIV_LO     16
`define STS_BUSY       0
`define STS_DONE       1
`define STS_POWER      2

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define CONFIG_RESET   32'h0000_0000
`define TIMING_RESET   32'h0000_0101

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CLK_HZ         200000000
`define SAR_MAX_HZ     18000000
`define SAR_DIV_MIN    ((`CLK_HZ + `SAR_MAX_HZ - 1) / `SAR_MAX_HZ)
`define FINISH_TICKS   4

`endif

/* adc_seq_pkg.sv */
/*
 Types of the conversion sequencer.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package adc_seq_pkg;
  typedef enum logic [2:0] {
    ST_OFF, ST_IDLE, ST_PWRUP, ST_TRACK, ST_CONV, ST_FINISH
  } seq_state_e;
  typedef enum logic [1:0] {
    TRIG_SOFT, TRIG_HW, TRIG_EXT, TRIG_NONE
  } trig_src_e;
endpackage : adc_seq_pkg

/* sar_step_gen.sv */
/*
 Converter clock tick and divided sar_step_clock generator.
 Assumes the oscillator tick input is already synchronised.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_map.svh"

module sar_step_gen #(
  parameter int DIV_W = 6
) (
  // Clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             nrst_i,
  // Control
  input  wire logic             clk_src_i,
  input  wire logic             osc_tick_i,
  input  wire logic             restart_i,
  input  wire logic [DIV_W-1:0] div_i,
  // Ticks
  output logic                  conv_tick_o,
  output logic                  sar_tick_o,
  output logic                  sar_clk_o
);
  localparam int MIN_RATIO = `SAR_DIV_MIN;

  // Elaboration check
  if ((1 << (DIV_W + 1)) <= MIN_RATIO) begin : g_chk_div
    $error("DIV_W too narrow for the minimum step ratio");
  end

  logic [DIV_W:0] cnt;
  logic [DIV_W:0] ratio;
  logic           tick;

  // Ratio clamped so the step clock never passes its ceiling
  assign ratio = ({1'b0, div_i} + 1'b1 < (DIV_W+1)'(MIN_RATIO)) ?
                 (DIV_W+1)'(MIN_RATIO) : {1'b0, div_i} + 1'b1;
  assign tick  = clk_src_i ? osc_tick_i : 1'b1;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt         <= '0;
      conv_tick_o <= 1'b0;
      sar_tick_o  <= 1'b0;
      sar_clk_o   <= 1'b0;
    end else begin
      conv_tick_o <= tick;
      sar_tick_o  <= 1'b0;
      if (restart_i) begin
        cnt       <= '0;
        sar_clk_o <= 1'b0;
      end else if (tick) begin
        if (cnt == ratio - 1'b1) begin
          cnt        <= '0;
          sar_tick_o <= 1'b1;
          sar_clk_o  <= 1'b0;
        end else begin
          cnt <= cnt + 1'b1;
          if (cnt == (ratio >> 1)) sar_clk_o <= 1'b1;
        end
      end
    end
  end
endmodule : sar_step_gen

`default_nettype wire

/* adc_conversion_sequencer.sv */
/*
 Conversion sequencer: power-up, tracking and conversion phases,
 trigger selection, accumulation and register file on AHB-Lite.
 Assumes a same-clock hardware event and an analog SAR core whose
 result is valid at the end of the conversion phase.
*/
// Design decisions made here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_map.svh"

module adc_conversion_sequencer
  import adc_seq_pkg::*;
#(
  parameter int CNT_W = 6,
  parameter int RPT_W = 3
) (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [7:0]  haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic [31:0]      hrdata_o,
  // Trigger sources and converter oscillator
  input  wire logic        hw_event_i,
  input  wire logic        external_convert_start_i,
  input  wire logic        high_freq_oscillator_i,
  // Analog core
  input  wire logic [11:0] core_result_i,
  output logic             power_on_o,
  output logic             track_o,
  output logic             convert_o,
  output logic             sar_step_clock_o
);
  // Room for up to 2**(2**RPT_W - 1) summed 12-bit results
  localparam int ACC_W = 12 + (1 << RPT_W) - 1;

  // Elaboration checks
  if (CNT_W < 4) begin : g_chk_cnt
    $error("CNT_W must cover the 13 conversion steps");
  end
  if (RPT_W < 1 || RPT_W > 3) begin : g_chk_rpt
    $error("RPT_W must be 1 to 3");
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [31:0]      config_reg;
  logic [31:0]      timing_reg;
  logic             done_flag;
  logic [ACC_W-1:0] accum;
  logic [ACC_W-1:0] result;

  logic             dp_write;
  logic             dp_valid;
  logic [7:0]       dp_addr;

  logic             cfg_enable;
  logic             power_off_after_conversion;
  trig_src_e        trigger_source_select;
  logic             resolution_select;
  logic             converter_clock_source;
  logic [RPT_W-1:0] repeat_count_field;
  logic [CNT_W-1:0] track_time_field;
  logic [CNT_W-1:0] power_up_time_field;
  logic [CNT_W-1:0] sar_divider_field;

  assign cfg_enable = config_reg[`CFG_ENABLE];
  assign power_off_after_conversion = config_reg[`CFG_POWER_OFF];
  assign trigger_source_select =
    trig_src_e'(config_reg[`CFG_TRIG_LO +: 2]);
  assign resolution_select = config_reg[`CFG_RES_SEL];
  assign converter_clock_source = config_reg[`CFG_CLK_SRC];
  assign repeat_count_field = config_reg[`CFG_RPT_LO +: RPT_W];
  assign track_time_field = timing_reg[`TIM_TRACK_LO +: CNT_W];
  assign power_up_time_field = timing_reg[`TIM_PWR_LO +: CNT_W];
  assign sar_divider_field = timing_reg[`TIM_DIV_LO +: CNT_W];

  // ------------------------------------------------------------
  // Decoding helpers
  // ------------------------------------------------------------
  function automatic logic [CNT_W-1:0] steps_of(input logic res10);
    // Resolution bits plus one
    steps_of = res10 ? CNT_W'(11) : CNT_W'(13);
  endfunction : steps_of

  function automatic logic [7:0] repeat_of(input logic [RPT_W-1:0] f);
    repeat_of = 8'(1) << f;
  endfunction : repeat_of

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic [2:0] ext_sync;
  logic [2:0] osc_sync;
  logic       ext_pulse;
  logic       osc_tick;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext_sync <= 3'h0;
      osc_sync <= 3'h0;
    end else begin
      ext_sync <= {ext_sync[1:0], external_convert_start_i};
      osc_sync <= {osc_sync[1:0], high_freq_oscillator_i};
    end
  end

  assign ext_pulse = ext_sync[1] & ~ext_sync[2];
  assign osc_tick = osc_sync[1] & ~osc_sync[2];

  // ------------------------------------------------------------
  // Step clock
  // ------------------------------------------------------------
  seq_state_e state;
  seq_state_e next_state;
  logic       conv_tick;
  logic       sar_tick;
  logic       sar_clk;
  logic       restart;

  sar_step_gen #(.DIV_W(CNT_W)) u_step (
    .ref_clk_i  (ref_clk_i),
    .nrst_i     (nrst_i),
    .clk_src_i  (converter_clock_source),
    .osc_tick_i (osc_tick),
    .restart_i  (restart),
    .div_i      (sar_divider_field),
    .conv_tick_o(conv_tick),
    .sar_tick_o (sar_tick),
    .sar_clk_o  (sar_clk)
  );

  // ------------------------------------------------------------
  // Trigger
  // ------------------------------------------------------------
  logic soft_start;
  logic trig;

  assign soft_start = dp_write && dp_addr == `OFS_STATUS &&
                      hwdata_i[`STS_BUSY];

  always_comb begin
    case (trigger_source_select)
      TRIG_SOFT: trig = soft_start;
      TRIG_HW:   trig = hw_event_i;
      TRIG_EXT:  trig = ext_pulse;
      default:   trig = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  logic [CNT_W-1:0] cnt;
  logic [7:0]       conv_cnt;
  logic [2:0]       fin_cnt;
  logic             phase_end;
  logic             conv_end;
  logic             last_conv;
  logic             fin_end;
  seq_state_e       after_pwr;

  assign phase_end = sar_tick && (cnt + 1'b1 >= (state == ST_PWRUP ?
    power_up_time_field : state == ST_TRACK ? track_time_field :
    steps_of(resolution_select)));
  assign conv_end  = state == ST_CONV && phase_end;
  assign last_conv = conv_cnt + 1'b1 >= repeat_of(repeat_count_field);
  assign fin_end   = conv_tick && fin_cnt == 3'(`FINISH_TICKS - 1);
  // tracking after power-up; zero track goes straight on
  assign after_pwr = track_time_field == '0 ? ST_CONV : ST_TRACK;
  assign restart   = state == ST_IDLE;

  always_comb begin
    next_state = state;
    case (state)
      ST_OFF:
        if (cfg_enable) next_state = ST_IDLE;
      ST_IDLE:
        if (trig) begin
          if (power_off_after_conversion && power_up_time_field != '0)
            next_state = ST_PWRUP;
          else
            next_state = after_pwr;
        end
      ST_PWRUP:
        if (phase_end) next_state = after_pwr;
      ST_TRACK:
        if (phase_end) next_state = ST_CONV;
      ST_CONV:
        if (conv_end) begin
          if (last_conv) next_state = ST_FINISH;
          else next_state = after_pwr;
        end
      // four converter ticks to close the cycle
      ST_FINISH:
        if (fin_end) next_state = ST_IDLE;
      default: next_state = ST_OFF;
    endcase
    if (!cfg_enable) next_state = ST_OFF;
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) state <= ST_OFF;
    else state <= next_state;
  end

  // phase timing counter in step periods
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) cnt <= '0;
    else if (next_state != state || conv_end) cnt <= '0;
    else if (sar_tick) cnt <= cnt + 1'b1;
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      conv_cnt <= 8'h00;
      fin_cnt  <= 3'h0;
    end else begin
      if (state == ST_IDLE) conv_cnt <= 8'h00;
      else if (conv_end) conv_cnt <= conv_cnt + 8'h01;
      if (state != ST_FINISH) fin_cnt <= 3'h0;
      else if (conv_tick) fin_cnt <= fin_cnt + 3'h1;
    end
  end

  // 10-bit mode keeps the upper bits
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) accum <= '0;
    else if (state == ST_IDLE) accum <= '0;
    else if (conv_end)
      accum <= accum + ACC_W'(resolution_select ?
               {2'h0, core_result_i[11:2]} : core_result_i);
  end

  // result and done only after the last conversion
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      result    <= '0;
      done_flag <= 1'b0;
    end else begin
      if (state == ST_FINISH && fin_end) result <= accum;
      // Set wins over a clear in the same cycle
      if (state == ST_FINISH && fin_end) done_flag <= 1'b1;
      else if (dp_write && dp_addr == `OFS_STATUS &&
               hwdata_i[`STS_DONE]) done_flag <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Analog controls
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      power_on_o       <= 1'b0;
      track_o          <= 1'b0;
      convert_o        <= 1'b0;
      sar_step_clock_o <= 1'b0;
    end else begin
      // stays powered while enabled in power-on mode
      power_on_o <= next_state != ST_OFF &&
                    (!power_off_after_conversion ||
                     next_state != ST_IDLE);
      // continuous tracking when idle and powered
      track_o <= next_state == ST_TRACK ||
                 (next_state == ST_IDLE && !power_off_after_conversion);
      convert_o        <= next_state == ST_CONV;
      sar_step_clock_o <= sar_clk && next_state == ST_CONV;
    end
  end

  // ------------------------------------------------------------
  // AHB-Lite slave
  // ------------------------------------------------------------
  logic        addr_ok;
  logic [31:0] rd_value;

  assign addr_ok = hsel_i && hready_i && htrans_i[1];

  always_comb begin
    case (haddr_i)
      `OFS_CONFIG: rd_value = config_reg;
      `OFS_TIMING: rd_value = timing_reg;
      // busy reads 1 only in the conversion phase
      `OFS_STATUS: rd_value = {29'h0, power_on_o, done_flag,
                               state == ST_CONV};
      `OFS_RESULT: rd_value = 32'(result);
      default:     rd_value = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dp_valid    <= 1'b0;
      dp_write    <= 1'b0;
      dp_addr     <= 8'h00;
      hrdata_o    <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      dp_valid    <= addr_ok;
      dp_write    <= addr_ok && hwrite_i && hsize_i == 3'h2;
      dp_addr     <= haddr_i;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      if (addr_ok && !hwrite_i) hrdata_o <= rd_value;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      config_reg <= `CONFIG_RESET;
      timing_reg <= `TIMING_RESET;
    end else if (dp_write) begin
      if (dp_addr == `OFS_CONFIG) config_reg <= hwdata_i;
      if (dp_addr == `OFS_TIMING) timing_reg <= hwdata_i;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence s_conv_done;
    state == ST_CONV && conv_end;
  endsequence

  property p_pwrup_once;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    $rose(state == ST_PWRUP) |-> $past(state) == ST_IDLE;
  endproperty
  a_pwrup_once: assert property (p_pwrup_once)
    else $error("power-up not at cycle start");

  property p_no_pwrup_on;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (state == ST_IDLE && trig && !power_off_after_conversion)
      |=> state != ST_PWRUP;
  endproperty
  a_no_pwrup_on: assert property (p_no_pwrup_on)
    else $error("power-up delay in power-on mode");

  property p_hold;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    convert_o |-> !track_o;
  endproperty
  a_hold: assert property (p_hold)
    else $error("tracking while converting");

  property p_track_out;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    state == ST_TRACK |-> track_o && power_on_o;
  endproperty
  a_track_out: assert property (p_track_out)
    else $error("timed tracking not driven");

  property p_auto_next;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (s_conv_done and !last_conv && cfg_enable)
      |=> state == ST_TRACK || state == ST_CONV;
  endproperty
  a_auto_next: assert property (p_auto_next)
    else $error("no self-start of next conversion");

  property p_done;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (state == ST_FINISH && fin_end && cfg_enable)
      |=> done_flag && state == ST_IDLE && result == $past(accum);
  endproperty
  a_done: assert property (p_done)
    else $error("done flag or result missing");

  property p_ignore;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (state == ST_FINISH && !fin_end && trig && cfg_enable)
      |=> state == ST_FINISH;
  endproperty
  a_ignore: assert property (p_ignore)
    else $error("trigger accepted mid cycle");

  property p_ignore_run;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (state inside {ST_PWRUP, ST_TRACK} && !phase_end && trig && cfg_enable)
      |=> state == $past(state);
  endproperty
  a_ignore_run: assert property (p_ignore_run)
    else $error("trigger restarted a running cycle");

  property p_ext_pulse;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    ext_pulse |=> !ext_pulse;
  endproperty
  a_ext_pulse: assert property (p_ext_pulse)
    else $error("edge pulse longer than one cycle");

  property p_steps;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    state == ST_CONV |-> cnt < steps_of(resolution_select);
  endproperty
  a_steps: assert property (p_steps)
    else $error("conversion overran its steps");

  property p_finish_len;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    state == ST_FINISH |-> fin_cnt < 3'(`FINISH_TICKS);
  endproperty
  a_finish_len: assert property (p_finish_len)
    else $error("closing ticks overran");

endmodule : adc_conversion_sequencer

`default_nettype wire

/* adc_core_model.sv */
/*
 Stand-in for the analog sample-hold and SAR core, with phase timers.
 Assumes the sequencer outputs are registered on ref_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none

module adc_core_model (
  // Clock, reset, clear
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        clr_i,
  // Sequencer side
  input  wire logic        power_on_i,
  input  wire logic        convert_i,
  input  wire logic [11:0] level_i,
  output logic      [11:0] core_result_o,
  // Measurements: conversion count and lengths in clock cycles
  output var int           conv_count_o,
  output var int           conv_len_o,
  output var int           gap_len_o,
  output var int           lead_len_o
);
  logic [11:0] held;
  logic        conv_q;
  logic        pwr_q;
  logic        tgl;
  int          cnt_c;
  int          cnt_g;
  int          cnt_l;

  // --------------------------------------------------------------
  // Sample-hold
  // --------------------------------------------------------------
  // held value while converting and on alternate cycles outside it
  // Outside conversion the switch is open: junk that changes each cycle
  assign core_result_o = convert_i ? held : ~held ^ {12{tgl}};

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      held         <= 12'h000;
      conv_q       <= 1'b0;
      pwr_q        <= 1'b0;
      tgl          <= 1'b0;
      cnt_c        <= 0;
      cnt_g        <= 0;
      cnt_l        <= 0;
      conv_count_o <= 0;
      conv_len_o   <= 0;
      gap_len_o    <= 0;
      lead_len_o   <= 0;
    end else begin
      tgl    <= ~tgl;
      conv_q <= convert_i;
      pwr_q  <= power_on_i;
      cnt_c  <= convert_i ? cnt_c + 1 : 0;
      cnt_g  <= convert_i ? 0 : cnt_g + 1;
      cnt_l  <= (power_on_i && !pwr_q) ? 1 : cnt_l + 1;
      if (convert_i && !conv_q) begin
        held         <= level_i;
        conv_count_o <= conv_count_o + 1;
        if (conv_count_o == 0) begin
          lead_len_o <= cnt_l;
        end else begin
          gap_len_o <= cnt_g;
        end
      end
      if (!convert_i && conv_q) begin
        conv_len_o <= cnt_c;
      end
      if (clr_i) begin
        conv_count_o <= 0;
      end
    end
  end
endmodule : adc_core_model

`default_nettype wire

/* tb_top.sv */
/*
 Self-checking bench for the conversion sequencer.
 Assumes a zero-wait AHB-Lite slave and the core stand-in model.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_map.svh"

module tb_top;
  logic        clk, nrst, hsel, hwrite, hw_ev, ext, osc, clr;
  logic        hrdy, hresp, pwr, trk, cnv, stp, stp_q;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [11:0] res, lvl;
  int          fails, samples_checked, cc, cl, gl, ll, sc;

  adc_conversion_sequencer DUT (.ref_clk_i(clk), .nrst_i(nrst),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hrdy),
    .hreadyout_o(hrdy), .hresp_o(hresp), .hrdata_o(hrdata),
    .hw_event_i(hw_ev), .external_convert_start_i(ext),
    .high_freq_oscillator_i(osc), .core_result_i(res), .power_on_o(pwr),
    .track_o(trk), .convert_o(cnv), .sar_step_clock_o(stp));

  adc_core_model core (.ref_clk_i(clk), .nrst_i(nrst), .clr_i(clr),
    .power_on_i(pwr), .convert_i(cnv), .level_i(lvl),
    .core_result_o(res), .conv_count_o(cc), .conv_len_o(cl),
    .gap_len_o(gl), .lead_len_o(ll));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Oscillator unrelated in phase and rate to the bus clock
  initial begin
    osc = 1'b0;
    forever #3.1 osc = ~osc;
  end
  // Step clock pulses since the last clear
  always @(posedge clk) begin
    stp_q <= stp;
    sc    <= clr ? 0 : sc + int'(stp && !stp_q);
  end

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  function automatic int ratio(input int f);
    return (f + 1 < 12) ? 12 : f + 1;
  endfunction : ratio

  task automatic final_report;
    $display("Checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report

  task automatic chk_eq(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_eq

  // Phase lengths may land a cycle or two off a step boundary
  task automatic chk_near(input int got, input int exp);
    samples_checked++;
    if (got < exp - 2 || got > exp + 2) begin
      fails++;
      $display("MISMATCH %0t length %0d expected %0d", $time, got, exp);
    end
  endtask : chk_near

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= a;
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= wd;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask : bus

  // --------------------------------------------------------------
  // One triggered accumulation with random settings
  // --------------------------------------------------------------
  task automatic run(input int i);
    int   po, src, rs, ck, rp, tk, pu, dv, n, reps;
    logic seen;
    po   = $urandom % 2;
    src  = i % 4;
    rs   = $urandom % 2;
    ck   = (i == 5);
    rp   = (i == 0) ? 3 : (i == 4) ? 0 : $urandom % 4;
    tk   = (i == 4) ? 0 : 1 + $urandom % 6;
    pu   = 1 + $urandom % 3;
    dv   = $urandom % 16;
    reps = 1 << rp;
    seen = 1'b0;
    n    = 0;
    // zero track only for one conversion, power-up nonzero
    bus(1'b1, `OFS_TIMING, tk | pu << 8 | dv << 16);
    bus(1'b1, `OFS_CONFIG, 1 | po << 1 | src << 2 | rs << 4 | ck << 5
        | rp << 8);
    repeat (40) @(posedge clk);
    lvl <= 12'($urandom);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    case (src)
      1: hw_ev <= 1'b1;
      2: ext <= 1'b1;
      default: bus(1'b1, `OFS_STATUS, 32'h1);
    endcase
    @(posedge clk);
    hw_ev <= 1'b0;
    if (src == 0) bus(1'b1, `OFS_STATUS, 32'h1);
    do begin
      bus(1'b0, `OFS_STATUS, 32'h0);
      seen |= rd[`STS_BUSY];
      n++;
    end while (!rd[`STS_DONE] && n < (src == 3 ? 30 : 4000));
    chk_eq(rd[`STS_DONE], src != 3);
    if (src != 3) begin
      chk_eq(cc, reps);
      chk_eq(sc, reps * (rs ? 11 : 13));
      chk_eq(rd[`STS_BUSY], 1'b0);
      chk_eq(seen, 1'b1);
      chk_eq(pwr, !po);
      if (!po) chk_eq(trk, 1'b1);
      bus(1'b0, `OFS_RESULT, 32'h0);
      chk_eq(rd, reps * (rs ? lvl[11:2] : lvl));
      if (!ck) begin
        chk_near(cl, (rs ? 11 : 13) * ratio(dv));
        if (reps > 1) chk_near(gl, tk * ratio(dv));
        if (po) chk_near(ll, (pu + tk) * ratio(dv));
      end
    end
    bus(1'b1, `OFS_STATUS, 32'h2);
    bus(1'b0, `OFS_STATUS, 32'h0);
    chk_eq(rd[`STS_DONE], 1'b0);
    ext <= 1'b0;
  endtask : run

  // --------------------------------------------------------------
  // Main sequence and watchdog
  // --------------------------------------------------------------
  initial begin
    {nrst, hsel, hwrite, hw_ev, ext, clr} = 6'h00;
    {haddr, htrans, hwdata, lvl} = '0;
    hsize = 3'h2;
    fails = 0;
    samples_checked = 0;
    void'($urandom(27));
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    chk_eq({hresp, pwr, cnv}, 3'h0);
    bus(1'b0, `OFS_CONFIG, 32'h0);
    chk_eq(rd, `CONFIG_RESET);
    bus(1'b0, `OFS_TIMING, 32'h0);
    chk_eq(rd, `TIMING_RESET);
    bus(1'b1, 8'h10, 32'hffff_ffff);
    bus(1'b0, 8'h10, 32'h0);
    chk_eq(rd, 32'h0);
    for (int i = 0; i < 8; i++) run(i);
    final_report();
  end

  initial begin
    repeat (90000) @(posedge clk);
    fails++;
    final_report();
  end
endmodule : tb_top

`default_nettype wire
